// ==== rtl/iep_endpoint.sv ====
// USB IN endpoint configuration and buffer selection.
// Assumes an APB master on clk and a USB link engine on clk.
// What this block does
// - size byte counts eight-byte units
// - X and Y share one length
// - isochronous: size is one circular buffer
// - eleven-bit X start from byte
// - low three start bits are zero
// - bit 7 enables endpoint
// - setup stage accepted even when disabled
// - bit 6 selects isochronous mode
// - toggle flips after successful data stage, except in isochronous mode
// - toggle zero DATA0, one DATA1
// - bit 4 uses X and Y outside isochronous mode
// - single mode uses only X
// - stall bit forces STALL handshake
// - bit 2 gates endpoint interrupt
// - bits 1:0 reserved, no function
// - Y start formed like X start
// - sent buffer sets empty flag, software clears
`timescale 1ns/100ps
module iep_endpoint
    import iep_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_token,
    input  wire logic        setup_token,
    input  wire logic        data_acked,
    output logic      [1:0]  handshake,
    output logic      [3:0]  data_pid,
    output logic             setup_accept,
    output logic      [10:0] buf_base,
    output logic      [10:0] buf_length,
    output logic      [6:0]  pkt_count,
    output logic             circular_mode,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             endpoint_irq
);
    // Registers
    logic [7:0] in_ep_buffer_size;
    logic [7:0] in_ep_x_buffer_start;
    logic [7:0] in_ep_y_buffer_start;
    logic [7:0] in_ep_configuration;
    logic [7:0] x_packet_count;
    logic [7:0] y_packet_count;
    logic       use_y;
    logic       irq_pending;
    iep_state_t state;
    iep_state_t next_state;
    iep_hs_t    next_hs;

    function automatic logic [10:0] start_addr(input logic [7:0] b);
        start_addr = {b, {IEP_ALIGN_W{1'b0}}};
    endfunction

    // Bus decode
    wire wr_en  = psel && penable && pwrite && pready;
    wire acc    = psel && penable;
    wire hit_sz = (paddr == IEP_OFF_SIZE);
    wire hit_xs = (paddr == IEP_OFF_XSTART);
    wire hit_ys = (paddr == IEP_OFF_YSTART);
    wire hit_cf = (paddr == IEP_OFF_CONFIG);
    wire hit_xc = (paddr == IEP_OFF_XCOUNT);
    wire hit_yc = (paddr == IEP_OFF_YCOUNT);
    wire hit_st = (paddr == IEP_OFF_STATUS);
    wire hit_ff = (paddr == IEP_OFF_FIFO);
    wire mapped = hit_sz || hit_xs || hit_ys || hit_cf || hit_xc
                  || hit_yc || hit_st || hit_ff;

    // Write strobes; a FIFO write lands only once there is room
    wire wr_sz     = wr_en && hit_sz;
    wire wr_xs     = wr_en && hit_xs;
    wire wr_ys     = wr_en && hit_ys;
    wire wr_cf     = wr_en && hit_cf;
    wire wr_xc     = wr_en && hit_xc;
    wire wr_yc     = wr_en && hit_yc;
    wire wr_st     = wr_en && hit_st;
    wire irq_clear = wr_st && pwdata[0];

    // Configuration fields
    wire cfg_on     = in_ep_configuration[IEP_CFG_ON];
    wire cfg_iso    = in_ep_configuration[IEP_CFG_ISO];
    wire cfg_toggle = in_ep_configuration[IEP_CFG_TOGGLE];
    wire cfg_dual   = in_ep_configuration[IEP_CFG_DUAL];
    wire cfg_stall  = in_ep_configuration[IEP_CFG_STALL];
    wire cfg_irq    = in_ep_configuration[IEP_CFG_IRQ];

    // Active buffer: Y only in double-buffer mode
    wire sel_y = cfg_dual && use_y && !cfg_iso;
    wire [7:0] act_count = sel_y ? y_packet_count : x_packet_count;
    wire act_empty = act_count[IEP_CNT_EMPTY] && !cfg_iso;

    // FIFO path from software writes to the link
    wire       fifo_in_valid = wr_en && hit_ff;
    wire       fifo_in_ready;
    wire       fifo_empty;
    wire       fifo_out_valid;
    wire       stream_on = (state == IEP_ST_SEND);

    iep_fifo #(
        .WIDTH (IEP_FIFO_W),
        .DEPTH (IEP_FIFO_D)
    ) iep_fifo_inst (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .in_valid   (fifo_in_valid),
        .in_ready   (fifo_in_ready),
        .in_data    (pwdata[7:0]),
        .out_valid  (fifo_out_valid),
        .out_ready  (tx_ready && stream_on),
        .out_data   (tx_data),
        .flush_done (fifo_empty)
    );

    // FIFO writes stall the bus while full
    assign pready  = !(psel && hit_ff && pwrite && !fifo_in_ready);
    assign pslverr = acc && !mapped;
    // Offer bytes only while a packet is being sent
    assign tx_valid = fifo_out_valid && stream_on;

    // Buffer geometry outputs
    assign buf_base      = sel_y ? start_addr(in_ep_y_buffer_start)
                                 : start_addr(in_ep_x_buffer_start);
    assign buf_length    = {in_ep_buffer_size, {IEP_ALIGN_W{1'b0}}};
    assign circular_mode = cfg_iso;
    assign pkt_count     = act_count[6:0];
    assign data_pid      = cfg_toggle ? IEP_PID_DATA1 : IEP_PID_DATA0;
    assign setup_accept  = setup_token;
    assign endpoint_irq  = irq_pending && cfg_irq;

    // Transaction decision
    always_comb
    begin
        next_state = state;
        next_hs    = IEP_HS_NONE;
        unique case (state)
            IEP_ST_IDLE:
            begin
                if (in_token && cfg_stall)
                begin
                    next_hs = IEP_HS_STALL;
                end
                else if (in_token && cfg_on && act_empty)
                begin
                    next_hs = IEP_HS_NAK;
                end
                else if (in_token && cfg_on)
                begin
                    next_hs    = IEP_HS_DATA;
                    next_state = IEP_ST_SEND;
                end
            end
            IEP_ST_SEND:
            begin
                if (fifo_empty)
                begin
                    next_state = IEP_ST_WAIT;
                end
            end
            IEP_ST_WAIT:
            begin
                if (data_acked)
                begin
                    next_state = IEP_ST_IDLE;
                end
            end
            default:
            begin
                next_state = IEP_ST_IDLE;
            end
        endcase
    end

    wire done = (state == IEP_ST_WAIT) && data_acked;
    wire done_x = done && !sel_y;
    wire done_y = done && sel_y;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state     <= IEP_ST_IDLE;
            handshake <= IEP_HS_NONE;
        end
        else
        begin
            state     <= next_state;
            handshake <= next_hs;
        end
    end

    // Size and start bytes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            in_ep_buffer_size    <= IEP_RST_BYTE;
            in_ep_x_buffer_start <= IEP_RST_BYTE;
            in_ep_y_buffer_start <= IEP_RST_BYTE;
        end
        else
        begin
            if (wr_sz)
            begin
                in_ep_buffer_size <= pwdata[7:0];
            end
            if (wr_xs)
            begin
                in_ep_x_buffer_start <= pwdata[7:0];
            end
            if (wr_ys)
            begin
                in_ep_y_buffer_start <= pwdata[7:0];
            end
        end
    end

    // Configuration byte; hardware toggle wins over a write
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            in_ep_configuration <= IEP_RST_BYTE;
        end
        else
        begin
            if (wr_cf)
            begin
                in_ep_configuration <= pwdata[7:0] & IEP_CFG_WMASK;
            end
            if (done && !cfg_iso)
            begin
                in_ep_configuration[IEP_CFG_TOGGLE] <= !cfg_toggle;
            end
        end
    end

    // Count bytes; empty flag set wins over software clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            x_packet_count <= IEP_RST_BYTE;
            y_packet_count <= IEP_RST_BYTE;
        end
        else
        begin
            if (wr_xc)
            begin
                x_packet_count <= pwdata[7:0];
            end
            if (wr_yc)
            begin
                y_packet_count <= pwdata[7:0];
            end
            if (done_x)
            begin
                x_packet_count[IEP_CNT_EMPTY] <= 1'b1;
            end
            if (done_y)
            begin
                y_packet_count[IEP_CNT_EMPTY] <= 1'b1;
            end
        end
    end

    // Alternate buffers after each packet in double-buffer mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            use_y <= 1'b0;
        end
        else if (done)
        begin
            use_y <= cfg_dual && !use_y;
        end
    end

    // Packet-sent event; a clear in the same cycle loses
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_pending <= 1'b0;
        end
        else if (done)
        begin
            irq_pending <= 1'b1;
        end
        else if (irq_clear)
        begin
            irq_pending <= 1'b0;
        end
    end

    // Read mux
    wire [7:0] status_byte = {4'h0, state == IEP_ST_IDLE, fifo_empty,
                              use_y, irq_pending};
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (hit_sz)
        begin
            prdata[7:0] = in_ep_buffer_size;
        end
        else if (hit_xs)
        begin
            prdata[7:0] = in_ep_x_buffer_start;
        end
        else if (hit_ys)
        begin
            prdata[7:0] = in_ep_y_buffer_start;
        end
        else if (hit_cf)
        begin
            prdata[7:0] = in_ep_configuration;
        end
        else if (hit_xc)
        begin
            prdata[7:0] = x_packet_count;
        end
        else if (hit_yc)
        begin
            prdata[7:0] = y_packet_count;
        end
        else if (hit_st)
        begin
            prdata[7:0] = status_byte;
        end
    end
endmodule

// ==== rtl/iep_pkg.sv ====
// Package for the USB IN endpoint configuration block.
// Assumes an APB slave with 32-bit data, one word per register.
package iep_pkg;
    // Register byte offsets
    localparam logic [7:0] IEP_OFF_SIZE   = 8'h00;
    localparam logic [7:0] IEP_OFF_XSTART = 8'h04;
    localparam logic [7:0] IEP_OFF_YSTART = 8'h08;
    localparam logic [7:0] IEP_OFF_CONFIG = 8'h0C;
    localparam logic [7:0] IEP_OFF_XCOUNT = 8'h10;
    localparam logic [7:0] IEP_OFF_YCOUNT = 8'h14;
    localparam logic [7:0] IEP_OFF_STATUS = 8'h18;
    localparam logic [7:0] IEP_OFF_FIFO   = 8'h1C;
    // Configuration bit positions
    localparam int IEP_CFG_ON     = 7;
    localparam int IEP_CFG_ISO    = 6;
    localparam int IEP_CFG_TOGGLE = 5;
    localparam int IEP_CFG_DUAL   = 4;
    localparam int IEP_CFG_STALL  = 3;
    localparam int IEP_CFG_IRQ    = 2;
    // Count byte: empty flag in bit 7, count in 6:0
    localparam int IEP_CNT_EMPTY  = 7;
    // Reset value and configuration write mask
    localparam logic [7:0] IEP_RST_BYTE  = 8'h00;
    localparam logic [7:0] IEP_CFG_WMASK = 8'hFC;
    // Buffer geometry
    localparam int IEP_ADDR_W   = 11;
    localparam int IEP_ALIGN_W  = 3;
    localparam int IEP_FIFO_W   = 8;
    localparam int IEP_FIFO_D   = 8;
    // Handshake codes to the link logic
    typedef enum logic [1:0]
    {
        IEP_HS_NONE  = 2'b00,
        IEP_HS_DATA  = 2'b01,
        IEP_HS_NAK   = 2'b10,
        IEP_HS_STALL = 2'b11
    } iep_hs_t;
    typedef enum logic [1:0]
    {
        IEP_ST_IDLE = 2'b00,
        IEP_ST_SEND = 2'b01,
        IEP_ST_WAIT = 2'b10
    } iep_state_t;
    localparam logic [3:0] IEP_PID_DATA0 = 4'h3;
    localparam logic [3:0] IEP_PID_DATA1 = 4'hB;
endpackage

// ==== rtl/iep_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/100ps
module iep_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  flush_done
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW])
                              && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = in_valid && !full;
    wire              pop   = out_ready && !empty;

    assign in_ready   = !full;
    assign out_valid  = !empty;
    assign out_data   = mem[rd_ptr[AW-1:0]];
    assign flush_done = empty;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ==== verif/iep_chk.sv ====
// Port checker for iep_endpoint.
// Assumes binding onto every iep_endpoint instance.
`timescale 1ns/100ps
module iep_chk
    import iep_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        in_token,
    input wire logic        setup_token,
    input wire logic        data_acked,
    input wire logic [1:0]  handshake,
    input wire logic [3:0]  data_pid,
    input wire logic        setup_accept,
    input wire logic [10:0] buf_base,
    input wire logic [10:0] buf_length,
    input wire logic        circular_mode,
    input wire logic        endpoint_irq
);
    logic [7:0] mr [0:3];
    logic       busy;
    wire        wr = psel & penable & pready & pwrite;
    wire        idle_tok = in_token & ~busy;
    wire [7:0]  cf = mr[3];
    // Mirror of size, starts and config, toggle tracked on ack
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mr <= '{default: 8'h00};
        else
        begin
            if (wr && paddr < 8'h10)
                mr[paddr[3:2]] <= pwdata[7:0];
            // Hardware toggle wins over a config write
            if (data_acked && busy && !cf[6])
                mr[3][5] <= ~cf[5];
        end
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            busy <= 1'b0;
        else if (handshake == IEP_HS_DATA)
            busy <= 1'b1;
        else if (data_acked)
            busy <= 1'b0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_len;
        buf_length == {mr[0], 3'b000};
    endproperty
    a_len: assert property (p_len)
        else $error("buffer length wrong");
    property p_base;
        !cf[4] || cf[6] |-> buf_base == {mr[1], 3'b000};
    endproperty
    a_base: assert property (p_base)
        else $error("X base wrong");
    property p_pid;
        data_pid == (cf[5] ? IEP_PID_DATA1 : IEP_PID_DATA0);
    endproperty
    a_pid: assert property (p_pid)
        else $error("data pid wrong");
    property p_stall;
        idle_tok && cf[3] |=> handshake == IEP_HS_STALL;
    endproperty
    a_stall: assert property (p_stall)
        else $error("no stall");
    property p_off;
        idle_tok && !cf[3] && !cf[7] |=> handshake == IEP_HS_NONE;
    endproperty
    a_off: assert property (p_off)
        else $error("disabled endpoint answered");
    property p_setup;
        setup_accept == setup_token;
    endproperty
    a_setup: assert property (p_setup)
        else $error("setup not accepted");
    property p_iso;
        circular_mode == cf[6];
    endproperty
    a_iso: assert property (p_iso)
        else $error("mode wrong");
    property p_irq;
        endpoint_irq |-> cf[2];
    endproperty
    a_irq: assert property (p_irq)
        else $error("masked irq raised");
endmodule
bind iep_endpoint iep_chk iep_chk_inst (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pready        (pready),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .in_token      (in_token),
    .setup_token   (setup_token),
    .data_acked    (data_acked),
    .handshake     (handshake),
    .data_pid      (data_pid),
    .setup_accept  (setup_accept),
    .buf_base      (buf_base),
    .buf_length    (buf_length),
    .circular_mode (circular_mode),
    .endpoint_irq  (endpoint_irq)
);

// ==== verif/iep_host.sv ====
// Host model: IN and setup tokens, data sink, acknowledge.
// Assumes the endpoint's link ports on the same clock.
`timescale 1ns/100ps
module iep_host
    import iep_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [1:0] handshake,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       setup_accept,
    output logic            in_token,
    output logic            setup_token,
    output logic            data_acked,
    output logic            tx_ready
);
    initial
    begin
        in_token = 1'b0;
        setup_token = 1'b0;
        data_acked = 1'b0;
        tx_ready = 1'b0;
    end
    task automatic xfer(input logic slow, input int n,
        output logic [1:0] hs, output logic [7:0] last, output int got);
        int k;
        got = 0;
        last = 8'h00;
        @(posedge clk);
        in_token <= 1'b1;
        @(posedge clk);
        in_token <= 1'b0;
        @(negedge clk);
        hs = handshake;
        if (hs == IEP_HS_DATA)
        begin
            for (k = 0; k < 100 && got < n; k++)
            begin
                @(posedge clk);
                // Slow host takes every other cycle
                tx_ready <= !slow || k[0];
                @(negedge clk);
                if (tx_valid && tx_ready)
                begin
                    got++;
                    last = tx_data;
                end
            end
            @(posedge clk);
            tx_ready <= 1'b0;
            repeat (2) @(posedge clk);
            data_acked <= 1'b1;
            @(posedge clk);
            data_acked <= 1'b0;
        end
        #1;
    endtask
    task automatic setup(output logic acc);
        @(posedge clk);
        setup_token <= 1'b1;
        @(negedge clk);
        acc = setup_accept;
        @(posedge clk);
        setup_token <= 1'b0;
    endtask
endmodule

// ==== verif/iep_endpoint_test.sv ====
// Bench for iep_endpoint over APB with the host model.
// Assumes iep_pkg, iep_fifo, iep_host and iep_chk.
`timescale 1ns/100ps
`define CHK(n, g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("wrong value %s exp %0h got %0h", n, e, g); \
        end \
    end
module iep_endpoint_test
    import iep_pkg::*;
();
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        in_token, setup_token, data_acked, setup_accept;
    logic        circular_mode, tx_valid, tx_ready, endpoint_irq, acc;
    logic [7:0]  paddr, tx_data, last;
    logic [31:0] pwdata, prdata;
    logic [1:0]  handshake, hs;
    logic [3:0]  data_pid;
    logic [10:0] buf_base, buf_length;
    logic [6:0]  pkt_count;
    int          mismatches, checks, got;
    iep_endpoint iep_endpoint_inst (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .in_token      (in_token),
        .setup_token   (setup_token),
        .data_acked    (data_acked),
        .handshake     (handshake),
        .data_pid      (data_pid),
        .setup_accept  (setup_accept),
        .buf_base      (buf_base),
        .buf_length    (buf_length),
        .pkt_count     (pkt_count),
        .circular_mode (circular_mode),
        .tx_data       (tx_data),
        .tx_valid      (tx_valid),
        .tx_ready      (tx_ready),
        .endpoint_irq  (endpoint_irq)
    );
    iep_host iep_host_inst (
        .clk           (clk),
        .handshake     (handshake),
        .tx_data       (tx_data),
        .tx_valid      (tx_valid),
        .setup_accept  (setup_accept),
        .in_token      (in_token),
        .setup_token   (setup_token),
        .data_acked    (data_acked),
        .tx_ready      (tx_ready)
    );
    task automatic stop_test();
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Access phase ends at the edge that sees pready high
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            stop_test();
        end
        else
        begin
            @(negedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h000000, d}, r, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        `CHK("register", r, x)
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        wr(IEP_OFF_SIZE, 8'h18);
        wr(IEP_OFF_XSTART, 8'hA5);
        wr(IEP_OFF_YSTART, 8'h3C);
        wr(IEP_OFF_CONFIG, 8'hFF);
        rdc(IEP_OFF_CONFIG, 32'h000000FC);
        `CHK("length", buf_length, 11'h0C0)
        `CHK("circular", circular_mode, 1'b1)
        `CHK("base", buf_base, 11'h528)
        apb(1'b0, 8'h20, 32'h00000000, r, e);
        `CHK("unmapped", {e, r}, 33'h100000000)
    endtask
    task automatic t_stall();
        wr(IEP_OFF_CONFIG, 8'h88);
        iep_host_inst.xfer(1'b0, 0, hs, last, got);
        `CHK("stall", hs, IEP_HS_STALL)
        wr(IEP_OFF_CONFIG, 8'h00);
        iep_host_inst.xfer(1'b0, 0, hs, last, got);
        `CHK("disabled", hs, IEP_HS_NONE)
        iep_host_inst.setup(acc);
        `CHK("setup", acc, 1'b1)
    endtask
    task automatic t_data();
        wr(IEP_OFF_CONFIG, 8'h80);
        wr(IEP_OFF_XCOUNT, 8'h03);
        `CHK("count", pkt_count, 7'h03)
        for (int i = 1; i < 4; i++)
            wr(IEP_OFF_FIFO, 8'(i));
        `CHK("pid0", data_pid, IEP_PID_DATA0)
        iep_host_inst.xfer(1'b1, 3, hs, last, got);
        `CHK("data", {hs, last, 8'(got)}, {IEP_HS_DATA, 16'h0303})
        `CHK("pid1", data_pid, IEP_PID_DATA1)
        rdc(IEP_OFF_XCOUNT, 32'h00000083);
        `CHK("masked irq", endpoint_irq, 1'b0)
        iep_host_inst.xfer(1'b0, 0, hs, last, got);
        `CHK("nak", hs, IEP_HS_NAK)
        `CHK("x only", buf_base, 11'h528)
        wr(IEP_OFF_STATUS, 8'h01);
    endtask
    task automatic t_dual();
        wr(IEP_OFF_CONFIG, 8'h94);
        wr(IEP_OFF_XCOUNT, 8'h01);
        wr(IEP_OFF_YCOUNT, 8'h01);
        wr(IEP_OFF_FIFO, 8'h5A);
        `CHK("x base", buf_base, 11'h528)
        iep_host_inst.xfer(1'b0, 1, hs, last, got);
        `CHK("dual data", {hs, last}, {IEP_HS_DATA, 8'h5A})
        `CHK("y base", buf_base, 11'h1E0)
        `CHK("irq", endpoint_irq, 1'b1)
        wr(IEP_OFF_STATUS, 8'h01);
        `CHK("irq clear", endpoint_irq, 1'b0)
    endtask
    task automatic t_fifo();
        wr(IEP_OFF_CONFIG, 8'h80);
        wr(IEP_OFF_XCOUNT, 8'h09);
        for (int i = 0; i < 8; i++)
            wr(IEP_OFF_FIFO, 8'(i));
        fork
            wr(IEP_OFF_FIFO, 8'h99);
            begin
                repeat (4) @(negedge clk);
                `CHK("full", pready, 1'b0)
                iep_host_inst.xfer(1'b1, 9, hs, last, got);
            end
        join
        `CHK("drain", {last, 8'(got), tx_valid}, 17'h13212)
    endtask
    task automatic t_iso();
        wr(IEP_OFF_CONFIG, 8'hC0);
        iep_host_inst.xfer(1'b0, 0, hs, last, got);
        `CHK("iso data", hs, IEP_HS_DATA)
        `CHK("iso pid", data_pid, IEP_PID_DATA0)
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mismatches = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rdc(8'(4 * i), 32'h00000000);
        t_regs();
        t_stall();
        t_data();
        t_dual();
        t_fifo();
        t_iso();
        stop_test();
    end
endmodule
